// [hdl/cop_map.svh]
`ifndef COP_MAP_SVH
`define COP_MAP_SVH
// Source indices, highest priority first
`define SRC_VIDEO 0
`define SRC_COMP 1
`define SRC_IODMA 2
`define SRC_COP 3
`define NUM_SRC 4
// DMA accesses allowed before the CPU must own the bus again
`define DMA_LIMIT 3'h4
// Coprocessor DRAM interval, address strobe to acknowledge
`define DRAM_CLKS 4'h5
`define CAS_EXT_CLKS 4'h1
// Pin sampling edge plus one synchroniser edge before the FSM reacts
`define SYNC_LAT 4'h2
// Coprocessor access targets
`define TGT_DRAM 2'h0
`define TGT_ROM 2'h1
`define TGT_IO 2'h2
// Transceiver direction levels
`define DIR_TO_COP 1'b0
`define DIR_TO_SYS 1'b1
`endif

// [hdl/cop_pkg.sv]
`include "cop_map.svh"
package cop_pkg;
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_S_ADDR = 9'h002,
      ST_S_DATA = 9'h004,
      ST_S_ACK = 9'h008,
      ST_S_END = 9'h010,
      ST_M_WAIT = 9'h020,
      ST_M_ADDR = 9'h040,
      ST_M_DATA = 9'h080,
      ST_M_ACK = 9'h100
   } bst_t;
   typedef struct packed {
      logic [`NUM_SRC-1:0] owner;
      logic [2:0] count;
      logic holdoff;
      logic bus_req_n;
   } arb_state_t;
   typedef struct packed {
      bst_t st;
      logic [3:0] cnt;
      logic [5:0] s1;
      logic [5:0] s2;
      logic grant_n;
      logic cs_n;
      logic as_o;
      logic as_oe;
      logic ds_o;
      logic ds_oe;
      logic latch_oe_n;
      logic dir_n;
      logic xcvr_oe_n;
      logic cpu_read_data_en_n_n;
      logic ack_n;
      logic ale_o;
      logic ale_oe;
      logic xack_o;
      logic xack_oe;
      logic cas_ext;
   } top_state_t;
endpackage

// [hdl/arb_if.sv]
`timescale 1ns/1ns
`default_nettype none
`include "cop_map.svh"
interface arb_if;
   logic [`NUM_SRC-1:0] req;
   logic [`NUM_SRC-1:0] gnt;
   logic done;
   logic cpu_gnt;
   logic bus_req_n;
   modport arb (input req, done, cpu_gnt, output gnt, bus_req_n);
   modport user (output req, done, cpu_gnt, input gnt, bus_req_n);
endinterface
`default_nettype wire

// [hdl/dma_arbiter.sv]
`timescale 1ns/1ns
`default_nettype none
`include "cop_map.svh"
module dma_arbiter
   import cop_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Arbitration link
   arb_if.arb a
);
   arb_state_t s_r;
   arb_state_t s_nxt;

   // Fixed priority pick, video first and coprocessor last
   function automatic logic [`NUM_SRC-1:0] pick(input logic [`NUM_SRC-1:0] r);
      pick = '0;
      if (r[`SRC_VIDEO]) pick[`SRC_VIDEO] = 1'b1;
      else if (r[`SRC_COMP]) pick[`SRC_COMP] = 1'b1;
      else if (r[`SRC_IODMA]) pick[`SRC_IODMA] = 1'b1;
      else if (r[`SRC_COP]) pick[`SRC_COP] = 1'b1;
   endfunction

   // Ownership, access counting and CPU hold-off
   always_comb begin
      s_nxt = s_r;
      if (s_r.owner != '0) begin
         if (a.done) begin
            s_nxt.owner = '0;
            if (s_r.count == `DMA_LIMIT - 3'h1) begin
               s_nxt.count = '0;
               s_nxt.holdoff = 1'b1;
            end else begin
               s_nxt.count = s_r.count + 3'h1;
            end
         end
      end else if (!s_r.holdoff && a.cpu_gnt && a.req != '0) begin
         s_nxt.owner = pick(a.req);
      end else if (!a.cpu_gnt) begin
         s_nxt.count = '0;
      end
      if (s_r.holdoff && !a.cpu_gnt) begin
         s_nxt.holdoff = 1'b0;
      end
      // Bus granted with no request left: the CPU must take it back before the next grant
      if (s_nxt.owner == '0 && a.req == '0 && a.cpu_gnt) begin
         s_nxt.holdoff = 1'b1;
      end
      s_nxt.bus_req_n = !((a.req != '0 && !s_nxt.holdoff) ||
                          s_nxt.owner != '0);
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_r <= '{owner: '0, count: '0, holdoff: 1'b0, bus_req_n: 1'b1};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign a.gnt = s_r.owner; // Access in process keeps the bus
   assign a.bus_req_n = s_r.bus_req_n;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_idle_no_req: assert property (
      (a.req == '0 && s_r.owner == '0) |=> a.bus_req_n)
      else $error("bus requested with no source pending");
   a_req_raised: assert property (
      (a.req != '0 && !s_r.holdoff && !a.cpu_gnt) |=> !a.bus_req_n)
      else $error("pending source did not raise bus request");
   a_four_holdoff: assert property (
      (a.done && s_r.owner != '0 && s_r.count == `DMA_LIMIT - 3'h1)
      |=> (s_r.holdoff && a.gnt == '0))
      else $error("fourth access did not return bus to CPU");
   a_cop_lowest: assert property (
      a.gnt[`SRC_COP] && $past(a.gnt) == '0 |->
      $past(a.req[`NUM_SRC-2:0]) == '0 && $past(a.cpu_gnt))
      else $error("coprocessor granted over other requester");
   a_grant_onehot: assert property (
      $onehot0(a.gnt))
      else $error("more than one source owns the bus");
endmodule
`default_nettype wire

// [hdl/coproc_bus_master_interface.sv]
`timescale 1ns/1ns
`default_nettype none
`include "cop_map.svh"
module coproc_bus_master_interface
   import cop_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // Shared bus ownership with the CPU
   output logic SYSBUS_REQUEST_N,
   input wire logic CPU_BUSGNT_N,
   // Internal DMA sources
   input wire logic [2:0] DMA_REQ,
   input wire logic DMA_DONE,
   output logic [2:0] DMA_GNT,
   // CPU slave access decode
   input wire logic CPU_COP_SEL,
   input wire logic CPU_RD,
   output logic CPU_READ_DATA_EN_N,
   output logic CPU_ACK_N,
   // System bus address latch strobe, driven while the coprocessor masters
   output logic ALE_O,
   output logic ALE_OE,
   // Coprocessor strobes and acknowledge
   output logic COP_CHIP_SELECT_N,
   input wire logic COP_ADDR_STROBE_N_I,
   output logic COP_ADDR_STROBE_N_O,
   output logic COP_ADDR_STROBE_N_OE,
   input wire logic COP_DATA_STROBE_N_I,
   output logic COP_DATA_STROBE_N_O,
   output logic COP_DATA_STROBE_N_OE,
   input wire logic COP_XFER_ACK_N_I,
   output logic COP_XFER_ACK_N_O,
   output logic COP_XFER_ACK_N_OE,
   input wire logic COP_RD,
   // Coprocessor mastership
   input wire logic COP_BUS_REQ_N,
   output logic COP_BUS_GRANT_N,
   // Address latch and data transceivers
   output logic COP_ADDR_LATCH_OE_N,
   output logic COP_XCVR_DIR_N,
   output logic COP_XCVR_OE_N,
   // Target resource path
   input wire logic [1:0] COP_TARGET,
   input wire logic RES_DONE,
   input wire logic CAS_EXTEND_CFG,
   output logic COP_CAS_EXTEND
);
   top_state_t s_r;
   top_state_t s_nxt;
   arb_if arb ();
   logic as_n_s;
   logic ds_n_s;
   logic xack_n_s;
   logic breq_n_s;
   logic rd_s;
   logic gnt_s;
   logic [3:0] dram_lim;

   // Synchronised pin views, second stage only
   assign {gnt_s, as_n_s, ds_n_s, xack_n_s, breq_n_s, rd_s} =
      {!s_r.s2[5], s_r.s2[4:0]};
   assign dram_lim = s_r.cas_ext ? `DRAM_CLKS + `CAS_EXT_CLKS
                                 : `DRAM_CLKS;

   // Arbiter hookup; tenure end counts the coprocessor once
   assign arb.req = {!breq_n_s && s_r.st != ST_M_WAIT ||
                     !breq_n_s && !s_r.grant_n, DMA_REQ};
   assign arb.done = DMA_DONE && arb.gnt[`SRC_COP-1:0] != '0 ||
                     s_r.st == ST_M_WAIT && breq_n_s;
   assign arb.cpu_gnt = gnt_s;

   dma_arbiter u_arb (
      .clk(CLK),
      .rst_b(RST_B),
      .a(arb.arb)
   );

   // Sequencer and registered pin levels
   always_comb begin
      s_nxt = s_r;
      s_nxt.s1 = {CPU_BUSGNT_N, COP_ADDR_STROBE_N_I, COP_DATA_STROBE_N_I,
                  COP_XFER_ACK_N_I, COP_BUS_REQ_N, COP_RD};
      s_nxt.s2 = s_r.s1;
      s_nxt.cas_ext = CAS_EXTEND_CFG;
      case (s_r.st)
         ST_IDLE: begin
            if (arb.gnt[`SRC_COP]) begin
               s_nxt.st = ST_M_WAIT;
            end else if (CPU_COP_SEL) begin
               s_nxt.st = ST_S_ADDR;
            end
         end
         ST_S_ADDR: s_nxt.st = ST_S_DATA;
         ST_S_DATA: begin
            if (!xack_n_s) begin
               s_nxt.st = ST_S_ACK;
            end
         end
         ST_S_ACK: s_nxt.st = ST_S_END;
         ST_S_END: begin
            if (!CPU_COP_SEL && xack_n_s) begin
               s_nxt.st = ST_IDLE;
            end
         end
         ST_M_WAIT: begin
            if (breq_n_s) begin
               s_nxt.st = ST_IDLE;
            end else if (!as_n_s) begin
               s_nxt.st = ST_M_ADDR;
               s_nxt.cnt = `SYNC_LAT + 4'h1;
            end
         end
         ST_M_ADDR: begin
            s_nxt.st = ST_M_DATA;
            s_nxt.cnt = s_r.cnt + 4'h1;
         end
         ST_M_DATA: begin
            s_nxt.cnt = s_r.cnt + 4'h1;
            if (COP_TARGET == `TGT_DRAM) begin
               if (s_nxt.cnt >= dram_lim) begin
                  s_nxt.st = ST_M_ACK;
               end
            end else if (RES_DONE) begin
               s_nxt.st = ST_M_ACK;
            end
         end
         ST_M_ACK: begin
            if (as_n_s) begin
               s_nxt.st = ST_M_WAIT;
            end
         end
         default: s_nxt.st = ST_IDLE;
      endcase

      // Pin levels follow the next state so every output is a flop
      s_nxt.grant_n = 1'b1;
      s_nxt.cs_n = 1'b1;
      s_nxt.as_o = 1'b1;
      s_nxt.as_oe = 1'b0;
      s_nxt.ds_o = 1'b1;
      s_nxt.ds_oe = 1'b0;
      s_nxt.latch_oe_n = 1'b1;
      s_nxt.dir_n = `DIR_TO_COP;
      s_nxt.xcvr_oe_n = 1'b1;
      s_nxt.cpu_read_data_en_n_n = 1'b1;
      s_nxt.ack_n = 1'b1;
      s_nxt.ale_o = 1'b0;
      s_nxt.ale_oe = 1'b0;
      s_nxt.xack_o = 1'b1;
      s_nxt.xack_oe = 1'b0;
      case (s_nxt.st)
         ST_IDLE: s_nxt.grant_n = 1'b1;
         ST_S_ADDR: begin
            s_nxt.cs_n = 1'b0;
            s_nxt.as_o = 1'b0;
            s_nxt.as_oe = 1'b1;
            s_nxt.ds_oe = 1'b1;
            s_nxt.latch_oe_n = 1'b0;
         end
         ST_S_DATA, ST_S_ACK: begin
            s_nxt.cs_n = 1'b0;
            s_nxt.as_o = 1'b0;
            s_nxt.as_oe = 1'b1;
            s_nxt.ds_o = 1'b0;
            s_nxt.ds_oe = 1'b1;
            s_nxt.xcvr_oe_n = 1'b0;
            s_nxt.dir_n = CPU_RD ? `DIR_TO_SYS : `DIR_TO_COP;
            s_nxt.cpu_read_data_en_n_n = s_nxt.st != ST_S_ACK;
            s_nxt.ack_n = s_nxt.st != ST_S_ACK;
         end
         ST_S_END: begin
            s_nxt.as_oe = 1'b1; // Drive strobes high before release
            s_nxt.ds_oe = 1'b1;
         end
         ST_M_WAIT: begin
            s_nxt.grant_n = 1'b0;
            s_nxt.ale_oe = 1'b1;
            s_nxt.xack_oe = 1'b1;
         end
         ST_M_ADDR: begin
            s_nxt.grant_n = 1'b0;
            s_nxt.ale_oe = 1'b1;
            s_nxt.ale_o = 1'b1;
            s_nxt.xack_oe = 1'b1;
            s_nxt.xcvr_oe_n = 1'b0;
            s_nxt.dir_n = `DIR_TO_SYS;
         end
         ST_M_DATA, ST_M_ACK: begin
            s_nxt.grant_n = 1'b0;
            s_nxt.ale_oe = 1'b1;
            s_nxt.xack_oe = 1'b1;
            s_nxt.xack_o = s_nxt.st != ST_M_ACK;
            s_nxt.xcvr_oe_n = 1'b0;
            s_nxt.dir_n = rd_s ? `DIR_TO_COP : `DIR_TO_SYS;
         end
         default: s_nxt.grant_n = 1'b1;
      endcase
   end

   // State register
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         s_r <= '{st: ST_IDLE, cnt: 4'h0, s1: 6'h3E, s2: 6'h3E,
                  grant_n: 1'b1, cs_n: 1'b1, as_o: 1'b1, as_oe: 1'b0,
                  ds_o: 1'b1, ds_oe: 1'b0, latch_oe_n: 1'b1,
                  dir_n: 1'b0, xcvr_oe_n: 1'b1, cpu_read_data_en_n_n: 1'b1,
                  ack_n: 1'b1, ale_o: 1'b0, ale_oe: 1'b0,
                  xack_o: 1'b1, xack_oe: 1'b0, cas_ext: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // Output pins
   assign SYSBUS_REQUEST_N = arb.bus_req_n;
   assign DMA_GNT = arb.gnt[`SRC_COP-1:0];
   assign CPU_READ_DATA_EN_N = s_r.cpu_read_data_en_n_n;
   assign CPU_ACK_N = s_r.ack_n;
   assign ALE_O = s_r.ale_o;
   assign ALE_OE = s_r.ale_oe;
   assign COP_CHIP_SELECT_N = s_r.cs_n;
   assign COP_ADDR_STROBE_N_O = s_r.as_o;
   assign COP_ADDR_STROBE_N_OE = s_r.as_oe;
   assign COP_DATA_STROBE_N_O = s_r.ds_o;
   assign COP_DATA_STROBE_N_OE = s_r.ds_oe;
   assign COP_XFER_ACK_N_O = s_r.xack_o;
   assign COP_XFER_ACK_N_OE = s_r.xack_oe;
   assign COP_BUS_GRANT_N = s_r.grant_n;
   assign COP_ADDR_LATCH_OE_N = s_r.latch_oe_n;
   assign COP_XCVR_DIR_N = s_r.dir_n;
   assign COP_XCVR_OE_N = s_r.xcvr_oe_n;
   assign COP_CAS_EXTEND = s_r.cas_ext;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   sequence dram_start;
      s_r.st == ST_M_WAIT && !as_n_s && !breq_n_s && COP_TARGET == `TGT_DRAM;
   endsequence
   a_dram_time: assert property (
      dram_start ##1 (!s_r.cas_ext && COP_TARGET == `TGT_DRAM) [*2]
      |-> COP_XFER_ACK_N_O ##1 !COP_XFER_ACK_N_O)
      else $error("coprocessor DRAM acknowledge not at five clocks");
   a_dram_ext: assert property (
      dram_start ##1 (s_r.cas_ext && COP_TARGET == `TGT_DRAM) [*3]
      |-> COP_XFER_ACK_N_O ##1 !COP_XFER_ACK_N_O)
      else $error("extended DRAM interval not one clock longer");
   a_slave_pair: assert property (
      s_r.st == ST_S_DATA && !xack_n_s |=> !CPU_ACK_N && !CPU_READ_DATA_EN_N
      ##1 CPU_ACK_N)
      else $error("CPU cycle not ended on coprocessor acknowledge");
   a_ale_pulse: assert property (
      $rose(ALE_O) |-> !COP_XCVR_OE_N && COP_XCVR_DIR_N == `DIR_TO_SYS
      ##1 !ALE_O)
      else $error("address phase latch pulse malformed");
   a_slave_strobe: assert property (
      !COP_CHIP_SELECT_N |-> !COP_ADDR_STROBE_N_O && COP_ADDR_STROBE_N_OE)
      else $error("chip select without address strobe");
   a_grant_drop: assert property (
      s_r.st == ST_M_WAIT && breq_n_s |=> COP_BUS_GRANT_N)
      else $error("grant held after coprocessor released bus");

   // Mastership exclusion, acknowledge hold, setting copy and slave latch enable
   a_grant_excl: assert property (
      !COP_BUS_GRANT_N |-> DMA_GNT == 3'h0 && COP_CHIP_SELECT_N &&
      !SYSBUS_REQUEST_N)
      else $error("coprocessor grant overlaps another bus user");
   a_ack_stands: assert property (
      s_r.st == ST_M_ACK && !as_n_s |=> !COP_XFER_ACK_N_O)
      else $error("transfer acknowledge dropped before strobe lift");
   a_cas_copy: assert property (
      COP_CAS_EXTEND == $past(CAS_EXTEND_CFG))
      else $error("CAS extension output does not follow its setting");
   a_slave_latch: assert property (
      s_r.st == ST_IDLE && CPU_COP_SEL && !arb.gnt[`SRC_COP]
      |=> !COP_ADDR_LATCH_OE_N)
      else $error("address latch not enabled for slave access");
endmodule
`default_nettype wire

// [dv/cop_partner.sv]
`timescale 1ns/1ns
`default_nettype none
module cop_partner (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // CPU bus ownership
   input wire logic sysbus_req_n,
   output logic cpu_gnt_n,
   // Strobe pins as driven by the block
   input wire logic cs_n,
   input wire logic as_n_o,
   input wire logic as_oe,
   input wire logic ds_n_o,
   input wire logic ds_oe,
   input wire logic xack_n_o,
   input wire logic xack_oe,
   // Resolved pin levels
   output logic as_n_i,
   output logic ds_n_i,
   output logic xack_n_i,
   // Coprocessor mastership and bench control
   input wire logic grant_n,
   output logic breq_n,
   input wire logic start,
   output logic done
);
   logic [1:0] gnt_d;
   logic m_as;
   logic m_ds;
   logic s_ack;
   logic [1:0] s_cnt;
   // Pulled-up strobe lines, low only while some party pulls them
   assign as_n_i = as_oe ? as_n_o : ~m_as;
   assign ds_n_i = ds_oe ? ds_n_o : ~m_ds;
   assign xack_n_i = xack_oe ? xack_n_o : ~s_ack;
   // CPU grants the bus, and takes it back, a few clocks after asking
   always @(posedge clk) begin
      if (!rst_b) begin
         gnt_d <= 2'h3;
         cpu_gnt_n <= 1'b1;
      end else begin
         gnt_d <= {gnt_d[0], sysbus_req_n};
         cpu_gnt_n <= gnt_d[1];
      end
   end
   // Master tenure of one access: request, address strobe, data strobe
   always @(posedge clk) begin
      if (!rst_b) begin
         breq_n <= 1'b1;
         m_as <= 1'b0;
         m_ds <= 1'b0;
         done <= 1'b0;
      end else if (start && !done) begin
         if (breq_n)
            breq_n <= 1'b0;
         else if (!grant_n && !m_as && xack_n_i)
            m_as <= 1'b1;
         else if (m_as && !m_ds)
            m_ds <= 1'b1;
         else if (m_ds && !xack_n_i) begin
            m_as <= 1'b0;
            m_ds <= 1'b0;
            done <= 1'b1;
            breq_n <= 1'b1;
         end
      end else if (!start)
         done <= 1'b0;
   end
   // Slave reply a few clocks after the data strobe, held until it lifts
   always @(posedge clk) begin
      if (!rst_b || cs_n || ds_n_i) begin
         s_cnt <= 2'h0;
         s_ack <= 1'b0;
      end else if (s_cnt == 2'h3)
         s_ack <= 1'b1;
      else
         s_cnt <= s_cnt + 2'h1;
   end
endmodule
`default_nettype wire

// [dv/coproc_bus_master_interface_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "cop_map.svh"
module coproc_bus_master_interface_tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [2:0] dma_req = 3'h0;
   logic [1:0] target = 2'h0;
   logic dma_done = 1'b0, cpu_sel = 1'b0, cpu_rd = 1'b0, cop_rd = 1'b0;
   logic res_done = 1'b0, cas_cfg = 1'b0, start = 1'b0;
   wire logic [2:0] dma_gnt;
   wire logic req_n, busgnt_n, rden_n, ack_n, ale_o, ale_oe, cs_n;
   wire logic as_n_i, as_n_o, as_oe, ds_n_i, ds_n_o, ds_oe;
   wire logic xack_n_i, xack_n_o, xack_oe, breq_n, gnt_n;
   wire logic latch_oe_n, dir_n, xoe_n, cas_ext, p_done;
   int miscompares = 0;
   int samples_checked = 0;
   // System clock, 20 ns period
   always #10 clk = ~clk;
   coproc_bus_master_interface i_dut (.CLK(clk), .RST_B(rst_b),
      .SYSBUS_REQUEST_N(req_n), .CPU_BUSGNT_N(busgnt_n),
      .DMA_REQ(dma_req), .DMA_DONE(dma_done), .DMA_GNT(dma_gnt),
      .CPU_COP_SEL(cpu_sel), .CPU_RD(cpu_rd), .CPU_READ_DATA_EN_N(rden_n),
      .CPU_ACK_N(ack_n), .ALE_O(ale_o), .ALE_OE(ale_oe),
      .COP_CHIP_SELECT_N(cs_n), .COP_ADDR_STROBE_N_I(as_n_i),
      .COP_ADDR_STROBE_N_O(as_n_o), .COP_ADDR_STROBE_N_OE(as_oe),
      .COP_DATA_STROBE_N_I(ds_n_i), .COP_DATA_STROBE_N_O(ds_n_o),
      .COP_DATA_STROBE_N_OE(ds_oe), .COP_XFER_ACK_N_I(xack_n_i),
      .COP_XFER_ACK_N_O(xack_n_o), .COP_XFER_ACK_N_OE(xack_oe),
      .COP_RD(cop_rd), .COP_BUS_REQ_N(breq_n), .COP_BUS_GRANT_N(gnt_n),
      .COP_ADDR_LATCH_OE_N(latch_oe_n), .COP_XCVR_DIR_N(dir_n),
      .COP_XCVR_OE_N(xoe_n), .COP_TARGET(target), .RES_DONE(res_done),
      .CAS_EXTEND_CFG(cas_cfg), .COP_CAS_EXTEND(cas_ext));
   cop_partner i_partner (.clk(clk), .rst_b(rst_b), .sysbus_req_n(req_n),
      .cpu_gnt_n(busgnt_n), .cs_n(cs_n), .as_n_o(as_n_o), .as_oe(as_oe),
      .ds_n_o(ds_n_o), .ds_oe(ds_oe), .xack_n_o(xack_n_o),
      .xack_oe(xack_oe), .as_n_i(as_n_i), .ds_n_i(ds_n_i),
      .xack_n_i(xack_n_i), .grant_n(gnt_n), .breq_n(breq_n),
      .start(start), .done(p_done));
   // Verdict and end of run
   task automatic print_verdict();
      if (miscompares == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Compare a group of output levels
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("ERROR %0t got %h expected %h", $time, got, exp);
         miscompares++;
      end
   endtask
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   // Conditions that the bench waits on
   function automatic logic probe(input int w);
      case (w)
         0: return |dma_gnt;
         1: return req_n;
         2: return ~ack_n;
         3: return ~gnt_n;
         4: return ~as_n_i;
         5: return p_done;
         6: return gnt_n;
         default: return 1'b0;
      endcase
   endfunction
   // Bounded wait; running out ends the run
   task automatic wait_for(input int w);
      int k;
      k = 0;
      while (probe(w) !== 1'b1) begin
         tick();
         k++;
         if (k > 200) begin
            $display("ERROR %0t wait %0d ran out", $time, w);
            miscompares++;
            print_verdict();
         end
      end
   endtask
   // Pulse the done strobe and drop the finished requests
   task automatic done_pulse(input logic [2:0] mask);
      @(posedge clk);
      dma_done <= 1'b1;
      dma_req <= dma_req & ~mask;
      @(posedge clk);
      dma_done <= 1'b0;
      tick();
   endtask
   // Idle levels after reset
   task automatic t_reset();
      chk({req_n, gnt_n, cs_n, ack_n}, 4'hF);
      chk({1'b0, dma_gnt} | {3'h0, ale_oe}, 4'h0);
      chk({latch_oe_n, xoe_n, rden_n, as_oe}, 4'hE);
   endtask
   // CPU access to the coprocessor
   task automatic t_slave(input logic rd);
      @(posedge clk);
      cpu_sel <= 1'b1;
      cpu_rd <= rd;
      tick();
      chk({cs_n, as_n_o, as_oe, latch_oe_n}, 4'h2);
      tick();
      chk({ds_n_o, ds_oe, xoe_n, dir_n},
         {3'h2, rd ? `DIR_TO_SYS : `DIR_TO_COP});
      wait_for(2);
      chk({ack_n, rden_n, 2'h0}, 4'h0);
      tick();
      chk({ack_n, rden_n, 2'h0}, 4'hC);
      @(posedge clk);
      cpu_sel <= 1'b0;
      repeat (8) tick();
      chk({cs_n, as_oe, ds_oe, 1'b0}, 4'h8);
   endtask
   // Three sources at once are served in rank order
   task automatic t_prio();
      @(posedge clk);
      dma_req <= 3'h7;
      for (int i = 0; i < 3; i++) begin
         wait_for(0);
         chk({req_n, dma_gnt}, {1'b0, 3'h1 << i});
         done_pulse(3'h1 << i);
      end
      wait_for(1);
      chk({1'b0, dma_gnt}, 4'h0);
   endtask
   // After four accesses the CPU must get the bus back
   task automatic t_limit();
      @(posedge clk);
      dma_req <= 3'h1;
      repeat (4) begin
         wait_for(0);
         done_pulse(3'h0);
      end
      wait_for(1);
      chk({1'b0, dma_gnt}, 4'h0);
      wait_for(0);
      chk({req_n, dma_gnt}, 4'h1);
      done_pulse(3'h1);
      wait_for(1);
   endtask
   // One coprocessor tenure with one access to the given target
   task automatic t_master(input logic [1:0] tgt, input logic ext,
      input logic rd);
      int n;
      int ale;
      n = 0;
      ale = 0;
      @(posedge clk);
      target <= tgt;
      cas_cfg <= ext;
      cop_rd <= rd;
      start <= 1'b1;
      wait_for(3);
      chk({req_n, busgnt_n, 2'h0}, 4'h0);
      wait_for(4);
      while (xack_oe !== 1'b1 || xack_n_o !== 1'b0) begin
         @(posedge clk);
         res_done <= (tgt != `TGT_DRAM && n == 6);
         #1;
         n++;
         if (ale_o === 1'b1) begin
            ale++;
            chk({ale_oe, dir_n, xoe_n, 1'b0}, {1'b1, `DIR_TO_SYS, 2'h0});
         end
         if (n > 40)
            wait_for(9);
      end
      chk(n[3:0], tgt == `TGT_DRAM ? `DRAM_CLKS + {3'h0, ext}
         : 4'h8);
      chk(ale[3:0], 4'h1);
      chk({cas_ext, dir_n, xoe_n, 1'b0},
         {ext, rd ? `DIR_TO_COP : `DIR_TO_SYS, 2'h0});
      wait_for(5);
      wait_for(6);
      @(posedge clk);
      start <= 1'b0;
      wait_for(1);
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      tick();
      t_reset();
      t_slave(1'b1);
      t_slave(1'b0);
      t_prio();
      t_limit();
      t_master(`TGT_DRAM, 1'b0, 1'b1);
      t_master(`TGT_DRAM, 1'b1, 1'b0);
      t_master(`TGT_ROM, 1'b0, 1'b0);
      t_master(`TGT_IO, 1'b0, 1'b1);
      print_verdict();
   end
endmodule
`default_nettype wire
